/* File: dv/tb.sv */
// self-checking bench for the output driver pop sequencer
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pop_seq_pkg::*;

   localparam int          DIV            = 2;
   localparam int unsigned PON_T  [0:11]  = '{0, 2, 4, 6, 8, 10, 12, 14, 16, 18, 20, 22};
   localparam int unsigned STEP_T [0:3]   = '{0, 1, 2, 3};
   localparam int unsigned SPKW_T [0:7]   = '{0, 3, 5, 7, 9, 11, 13, 15};

   logic       clk            = 1'b0;
   logic       resetn         = 1'b0;
   logic       reg_wr         = 1'b0;
   logic       reg_rd         = 1'b0;
   logic [7:0] reg_addr       = 8'h00;
   logic [7:0] reg_wdata      = 8'h00;
   logic       power_up_req   = 1'b0;
   logic       power_down_req = 1'b0;
   logic [7:0] reg_rdata;
   logic       hp_on;
   logic       cd_on;
   logic       dac_on;
   logic [3:0] gain;
   logic       cm_sel;
   logic       busy;
   int         errors         = 0;
   int         total_checks   = 0;
   int         seed           = 32'h33FCD4BF;
   int         r;

   output_driver_pop_sequencer #(.OSC_DIV_P(DIV), .GAIN_STEPS_P(8), .PON_TICKS_P(PON_T),
      .STEP_TICKS_P(STEP_T), .SPKW_TICKS_P(SPKW_T)) u_output_driver_pop_sequencer (
      .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_up_req(power_up_req),
      .power_down_req(power_down_req), .headphone_amplifiers_on(hp_on),
      .class_d_output_stages_on(cd_on), .dac_on(dac_on), .driver_gain(gain),
      .common_mode_select(cm_sel), .seq_busy(busy));

   always #2.5 clk = ~clk;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      check(nm, {24'h0, reg_rdata}, {24'h0, e});
   endtask

   function automatic logic in_rng(input int x, input int lo, input int hi);
      return (x >= lo && x <= hi);
   endfunction

   // one power-up then power-down; abort > 0 cuts the power-up short
   task automatic run_seq(input int pon, input int stp, input int spw, input logic ord, input int abort);
      int         t;
      int         t_cd;
      int         t_g;
      int         bad;
      int         q[$];
      int         eq[$];
      logic [3:0] last;
      logic [7:0] cfg;
      cfg = {ord, 4'(pon), 2'(stp), 1'b0};
      wr(8'h21, cfg);
      wr(8'h22, {1'b0, 3'(spw), 4'h0});
      rd_chk("pop_cfg", 8'h21, cfg);
      rd_chk("ramp_wait", 8'h22, {1'b0, 3'(spw), 4'h0});
      check("cm_sel", cm_sel, 0);
      @(negedge clk);
      power_up_req = 1'b1;
      @(negedge clk);
      power_up_req = 1'b0;
      check("up_first", {busy, dac_on, hp_on}, 3'b111);
      t = 0;
      t_cd = -1;
      t_g = -1;
      bad = 0;
      last = 4'h0;
      for (int i = 1; i <= 8; i++)
         eq.push_back(i);
      while (busy === 1'b1 && t < 3000 && !(abort > 0 && t == abort))
      begin
         @(negedge clk);
         t++;
         if (cd_on === 1'b1 && t_cd < 0)
            t_cd = t;
         if (t_cd >= 0 && (cd_on !== 1'b1 || hp_on !== 1'b1 || dac_on !== 1'b1))
            bad++;
         if (gain !== last)
         begin
            q.push_back(int'(gain));
            if (t_g < 0)
               t_g = t;
            last = gain;
         end
      end
      if (abort == 0)
      begin
         check("spk_wait", in_rng(t_cd, SPKW_T[spw] * DIV, SPKW_T[spw] * DIV + 2 * DIV + 2), 1);
         check("pon_wait", in_rng(t_g - t_cd, PON_T[pon] * DIV,
            (PON_T[pon] + STEP_T[stp]) * DIV + 2 * DIV + 4), 1);
         check("ramp_time", in_rng(t - t_cd, (PON_T[pon] + 8 * STEP_T[stp]) * DIV,
            (PON_T[pon] + 8 * STEP_T[stp]) * DIV + 8 * (DIV + 1) + 2 * DIV + 4), 1);
         check("up_levels", bad, 0);
         foreach (eq[i])
            check("gain_up", (i < q.size()) ? q[i] : -1, eq[i]);
      end
      @(negedge clk);
      power_down_req = 1'b1;
      @(negedge clk);
      power_down_req = 1'b0;
      check("dac_at_dn", dac_on, ord);
      t = 0;
      bad = 0;
      last = gain;
      while (busy === 1'b1 && t < 3000)
      begin
         @(negedge clk);
         t++;
         if (hp_on === 1'b1 && dac_on !== ord)
            bad++;
         if (gain !== last && gain !== last - 4'h1)
            bad++;
         last = gain;
      end
      check("dn_order", bad, 0);
      check("dn_end", {busy, hp_on, cd_on, dac_on, gain}, 0);
      if (abort == 0)
         check("dn_time", in_rng(t, 8 * STEP_T[stp] * DIV, 8 * STEP_T[stp] * DIV + 8 * (DIV + 1) + 6), 1);
      $display("test sequence pon %0d step %0d wait %0d order %0d done", pon, stp, spw, ord);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      check("rst_out", {busy, hp_on, cd_on, dac_on, gain, cm_sel}, 0);
      rd_chk("page_rst", 8'h00, 8'h00);
      rd_chk("off_page", 8'h21, 8'h00);
      wr(8'h21, 8'h00);
      wr(8'h00, 8'h01);
      rd_chk("page_set", 8'h00, 8'h01);
      rd_chk("cfg_rst", 8'h21, 8'h3E);
      rd_chk("wait_rst", 8'h22, 8'h00);
      rd_chk("unmapped", 8'h23, 8'h00);
      $display("test registers done");
      for (int p = 0; p < 12; p++)
         run_seq(p, p % 4, p % 8, p[0], 0);
      for (int k = 0; k < 4; k++)
      begin
         r = $random(seed);
         run_seq((r & 32'hFF) % 12, (r >> 8) & 3, (r >> 10) & 7, r[16], 0);
      end
      run_seq(11, 3, 7, 1'b1, 3);
      run_seq(5, 2, 0, 1'b0, 4);
      finish_test();
   end

   initial
   begin
      #300000;
      errors++;
      finish_test();
   end
endmodule

/* File: verilog/output_driver_pop_sequencer.sv */
// power-up / power-down sequencer for headphone and class-d output drivers
// Functional notes
// - four-bit power-on delay code selects none up to 6.1 s, twelve codes.
// - power-on delay code resets to 0111, meaning 304 ms.
// - two-bit ramp step code sets gain step interval 0 to 3.9 ms; reset 11.
// - all delays count internal oscillator ticks, nominal 8.2 MHz, scaling with it.
// - order bit 0: dac powers down together with the amplifiers.
// - order bit 1: dac stays powered until amplifiers finish powering down.
// - three-bit class-d wait code selects none up to 30.5 ms; reset 000.
module output_driver_pop_sequencer
#(
   parameter int unsigned OSC_DIV_P              = pop_seq_pkg::OSC_DIV,
   parameter int          GAIN_STEPS_P           = pop_seq_pkg::GAIN_STEPS,
   parameter int unsigned PON_TICKS_P  [0:11]    = pop_seq_pkg::PON_TICKS,
   parameter int unsigned STEP_TICKS_P [0:3]     = pop_seq_pkg::STEP_TICKS,
   parameter int unsigned SPKW_TICKS_P [0:7]     = pop_seq_pkg::SPKW_TICKS,
   parameter int          GAIN_W                 = $clog2(GAIN_STEPS_P + 1)
)
(
   input  wire logic              clk,                       // 200 MHz system clock
   input  wire logic              resetn,                    // synchronous reset, low
   input  wire logic              reg_wr,                    // register write strobe
   input  wire logic              reg_rd,                    // register read strobe
   input  wire logic [7:0]        reg_addr,                  // register offset in page
   input  wire logic [7:0]        reg_wdata,                 // write data
   output logic      [7:0]        reg_rdata,                 // read data, valid after rd
   input  wire logic              power_up_req,              // start power-up sequence
   input  wire logic              power_down_req,            // start power-down sequence
   output logic                   headphone_amplifiers_on,   // headphone drivers powered
   output logic                   class_d_output_stages_on,  // class-d stages powered
   output logic                   dac_on,                    // dac powered
   output logic      [GAIN_W-1:0] driver_gain,               // current gain step
   output logic                   common_mode_select,        // common-mode source bit
   output logic                   seq_busy                   // sequence in progress
);
   import pop_seq_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]        page_r;
   logic [7:0]        pop_cfg_r;
   logic [7:0]        ramp_wait_r;
   logic [7:0]        rdata_r;
   logic              on_page;
   logic [PON_W-1:0]  pon_code;
   logic [STEP_W-1:0] step_code;
   logic [SPKW_W-1:0] spkw_code;
   logic              dac_order;

   assign on_page   = (page_r == SEQ_PAGE);
   assign pon_code  = pop_cfg_r[PON_LSB +: PON_W];
   assign step_code = pop_cfg_r[STEP_LSB +: STEP_W];
   assign spkw_code = ramp_wait_r[SPKW_LSB +: SPKW_W];
   assign dac_order = pop_cfg_r[DAC_ORDER_BIT];

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         page_r      <= PAGE_CTRL_RST;
         pop_cfg_r   <= POP_CFG_RST;
         ramp_wait_r <= RAMP_WAIT_RST;
      end
      else if (reg_wr)
      begin
         if (reg_addr == PAGE_CTRL_OFS)
            page_r <= reg_wdata;
         else if (on_page && reg_addr == POP_CFG_OFS)
            pop_cfg_r <= reg_wdata;
         else if (on_page && reg_addr == RAMP_WAIT_OFS)
            ramp_wait_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         rdata_r <= 8'h00;
      else if (reg_rd)
      begin
         if (reg_addr == PAGE_CTRL_OFS)
            rdata_r <= page_r;
         else if (on_page && reg_addr == POP_CFG_OFS)
            rdata_r <= pop_cfg_r;
         else if (on_page && reg_addr == RAMP_WAIT_OFS)
            rdata_r <= ramp_wait_r;
         else
            rdata_r <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // oscillator tick divider
   // ------------------------------------------------------------
   logic [31:0] div_r;
   logic        osc_tick;
   logic [31:0] gap_r;

   always_ff @(posedge clk)
   begin
      if (!resetn)
         div_r <= 32'h0;
      else if (div_r >= OSC_DIV_P - 1)
         div_r <= 32'h0;
      else
         div_r <= div_r + 32'h1;
   end
   assign osc_tick = (div_r == OSC_DIV_P - 1);

   always_ff @(posedge clk)
      gap_r <= (!resetn || osc_tick) ? 32'h0 : gap_r + 32'h1;

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   seq_state_t        state_r;
   logic [31:0]       tick_r;
   logic [GAIN_W-1:0] gain_r;
   logic              hp_on_r;
   logic              cd_on_r;
   logic              dac_on_r;
   logic              dac_late_r;
   logic              busy_r;
   logic              timer_done;
   logic              dn_ok;

   assign timer_done = (tick_r == 32'h0);
   assign dn_ok = power_down_req && (state_r == ST_SPK_WAIT || state_r == ST_PON_WAIT ||
                                     state_r == ST_RAMP_UP || state_r == ST_ON);

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_r    <= ST_OFF;
         tick_r     <= 32'h0;
         gain_r     <= '0;
         hp_on_r    <= 1'b0;
         cd_on_r    <= 1'b0;
         dac_on_r   <= 1'b0;
         dac_late_r <= 1'b0;
         busy_r     <= 1'b0;
      end
      else if (dn_ok)
      begin
         state_r    <= ST_RAMP_DN;
         tick_r     <= STEP_TICKS_P[step_code];
         dac_late_r <= dac_order;
         busy_r     <= 1'b1;
         if (!dac_order)
            dac_on_r <= 1'b0;
      end
      else
      begin
         if (!timer_done && osc_tick)
            tick_r <= tick_r - 32'h1;
         case (state_r)
            ST_OFF:
               if (power_up_req)
               begin
                  state_r  <= ST_SPK_WAIT;
                  dac_on_r <= 1'b1;
                  hp_on_r  <= 1'b1;
                  tick_r   <= SPKW_TICKS_P[spkw_code];
                  busy_r   <= 1'b1;
               end
            ST_SPK_WAIT:
               if (timer_done)
               begin
                  state_r <= ST_PON_WAIT;
                  cd_on_r <= 1'b1;
                  tick_r  <= (pon_code < PON_CODES) ? PON_TICKS_P[pon_code] : PON_TICKS_P[PON_CODES-1];
               end
            ST_PON_WAIT:
               if (timer_done)
               begin
                  state_r <= ST_RAMP_UP;
                  tick_r  <= STEP_TICKS_P[step_code];
               end
            ST_RAMP_UP:
               if (gain_r == GAIN_W'(GAIN_STEPS_P))
               begin
                  state_r <= ST_ON;
                  busy_r  <= 1'b0;
               end
               else if (timer_done)
               begin
                  gain_r <= gain_r + GAIN_W'(1);
                  tick_r <= STEP_TICKS_P[step_code];
               end
            ST_ON:
               state_r <= ST_ON;
            ST_RAMP_DN:
               if (gain_r == '0)
               begin
                  state_r <= ST_DAC_OFF;
                  hp_on_r <= 1'b0;
                  cd_on_r <= 1'b0;
               end
               else if (timer_done)
               begin
                  gain_r <= gain_r - GAIN_W'(1);
                  tick_r <= STEP_TICKS_P[step_code];
               end
            ST_DAC_OFF:
            begin
               state_r  <= ST_OFF;
               dac_on_r <= 1'b0;
               busy_r   <= 1'b0;
            end
            default:
            begin
               state_r <= ST_OFF;
               busy_r  <= 1'b0;
            end
         endcase
      end
   end

   assign reg_rdata                = rdata_r;
   assign headphone_amplifiers_on  = hp_on_r;
   assign class_d_output_stages_on = cd_on_r;
   assign dac_on                   = dac_on_r;
   assign driver_gain              = gain_r;
   assign common_mode_select       = pop_cfg_r[CM_BIT];
   assign seq_busy                 = busy_r;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_reset_codes;
      @(posedge clk) !resetn |=> (pon_code == 4'h7 && step_code == 2'h3 && spkw_code == 3'h0);
   endproperty
   a_reset_codes: assert property (p_reset_codes) else $error("reset codes wrong");

   property p_pon_load;
      @(posedge clk) disable iff (!resetn)
      (state_r == ST_PON_WAIT && $past(state_r) == ST_SPK_WAIT)
         |-> tick_r == PON_TICKS_P[$past(pon_code)];
   endproperty
   a_pon_load: assert property (p_pon_load) else $error("power-on delay count wrong");

   property p_spkw_load;
      @(posedge clk) disable iff (!resetn)
      (state_r == ST_SPK_WAIT && $past(state_r) == ST_OFF) |-> tick_r == SPKW_TICKS_P[$past(spkw_code)];
   endproperty
   a_spkw_load: assert property (p_spkw_load) else $error("class-d wait count wrong");

   property p_step_load;
      @(posedge clk) disable iff (!resetn)
      (state_r == ST_RAMP_UP && gain_r != $past(gain_r)) |-> tick_r == STEP_TICKS_P[$past(step_code)];
   endproperty
   a_step_load: assert property (p_step_load) else $error("ramp step count wrong");

   property p_tick_hold;
      @(posedge clk) disable iff (!resetn)
      osc_tick |-> gap_r == OSC_DIV_P - 1;
   endproperty
   a_tick_hold: assert property (p_tick_hold) else $error("oscillator tick spacing wrong");

   property p_dac_together;
      @(posedge clk) disable iff (!resetn)
      (dn_ok && !dac_order) |=> (!dac_on_r && state_r == ST_RAMP_DN);
   endproperty
   a_dac_together: assert property (p_dac_together) else $error("dac not off with amplifiers");

   property p_dac_late;
      @(posedge clk) disable iff (!resetn)
      (dac_late_r && $fell(hp_on_r)) |-> dac_on_r ##1 !dac_on_r;
   endproperty
   a_dac_late: assert property (p_dac_late) else $error("dac order after amplifiers wrong");

   property p_gain_after_delay;
      @(posedge clk) disable iff (!resetn)
      (gain_r > $past(gain_r)) |-> ($past(state_r) == ST_RAMP_UP && $past(tick_r) == 32'h0);
   endproperty
   a_gain_after_delay: assert property (p_gain_after_delay) else $error("gain stepped early");

endmodule

/* File: verilog/pop_seq_pkg.sv */
// constants, register map and state codes of the output driver pop sequencer
package pop_seq_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] PAGE_CTRL_OFS = 8'h00;
   localparam logic [7:0] POP_CFG_OFS   = 8'h21;
   localparam logic [7:0] RAMP_WAIT_OFS = 8'h22;
   localparam logic [7:0] SEQ_PAGE      = 8'h01;

   localparam logic [7:0] PAGE_CTRL_RST = 8'h00;
   localparam logic [7:0] POP_CFG_RST   = 8'h3E;
   localparam logic [7:0] RAMP_WAIT_RST = 8'h00;

   // field positions
   localparam int DAC_ORDER_BIT = 7;
   localparam int PON_LSB       = 3;
   localparam int PON_W         = 4;
   localparam int STEP_LSB      = 1;
   localparam int STEP_W        = 2;
   localparam int CM_BIT        = 0;
   localparam int SPKW_LSB      = 4;
   localparam int SPKW_W        = 3;
   localparam int PON_CODES     = 12;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam longint unsigned CLK_MHZ_X10 = 2000;
   localparam longint unsigned OSC_MHZ_X10 = 82;
   localparam int unsigned OSC_DIV = 32'((CLK_MHZ_X10 + OSC_MHZ_X10 / 2) / OSC_MHZ_X10);

   localparam longint unsigned PON_NS [0:11] = '{64'd0, 64'd15300, 64'd153000, 64'd1530000,
      64'd15300000, 64'd76200000, 64'd153000000, 64'd304000000, 64'd610000000,
      64'd1220000000, 64'd3040000000, 64'd6100000000};
   localparam longint unsigned STEP_NS [0:3] = '{64'd0, 64'd980000, 64'd1950000, 64'd3900000};
   localparam longint unsigned SPKW_NS [0:7] = '{64'd0, 64'd3040000, 64'd7620000, 64'd12200000,
      64'd15300000, 64'd19800000, 64'd24400000, 64'd30500000};

   // least time in oscillator ticks, rounded up
   function automatic int unsigned ns_to_ticks(input longint unsigned ns);
      return 32'((ns * OSC_MHZ_X10 + 64'd9999) / 64'd10000);
   endfunction

   localparam int unsigned PON_TICKS [0:11] = '{ns_to_ticks(PON_NS[0]), ns_to_ticks(PON_NS[1]),
      ns_to_ticks(PON_NS[2]), ns_to_ticks(PON_NS[3]), ns_to_ticks(PON_NS[4]), ns_to_ticks(PON_NS[5]),
      ns_to_ticks(PON_NS[6]), ns_to_ticks(PON_NS[7]), ns_to_ticks(PON_NS[8]), ns_to_ticks(PON_NS[9]),
      ns_to_ticks(PON_NS[10]), ns_to_ticks(PON_NS[11])};
   localparam int unsigned STEP_TICKS [0:3] = '{ns_to_ticks(STEP_NS[0]), ns_to_ticks(STEP_NS[1]),
      ns_to_ticks(STEP_NS[2]), ns_to_ticks(STEP_NS[3])};
   localparam int unsigned SPKW_TICKS [0:7] = '{ns_to_ticks(SPKW_NS[0]), ns_to_ticks(SPKW_NS[1]),
      ns_to_ticks(SPKW_NS[2]), ns_to_ticks(SPKW_NS[3]), ns_to_ticks(SPKW_NS[4]), ns_to_ticks(SPKW_NS[5]),
      ns_to_ticks(SPKW_NS[6]), ns_to_ticks(SPKW_NS[7])};

   localparam int GAIN_STEPS = 8;

   typedef enum logic [2:0]
   {
      ST_OFF      = 3'b000,
      ST_SPK_WAIT = 3'b001,
      ST_PON_WAIT = 3'b010,
      ST_RAMP_UP  = 3'b011,
      ST_ON       = 3'b100,
      ST_RAMP_DN  = 3'b101,
      ST_DAC_OFF  = 3'b110
   } seq_state_t;

endpackage
